// ---- logic/fxa_core.sv ----
// Decided for this implementation: the address map and the APB interface to the registers.
`include "fxa_cfg.svh"
`default_nettype none
module fxa_core
  import fxa_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr
);

  // no reset on the array: contents stay undefined until written
  logic [7:0] mem [0:`FXA_MEM_WORDS-1];

  fxa_state_t              state_ff, nxt_state;
  logic [7:0]              work_ff, nxt_work;
  logic [4:0]              flags_ff, nxt_flags;
  logic [`FXA_MEM_AW-1:0]  addr_ff, nxt_addr;
  fxa_op_t                 op_ff, nxt_op;
  logic [2:0]              bit_ff, nxt_bit;
  logic [7:0]              opnd_ff, nxt_opnd;
  logic [31:0]             prdata_ff, nxt_prdata;
  logic                    pready_ff, nxt_pready;
  logic                    pslverr_ff, nxt_pslverr;
  logic                    mem_we;
  logic [7:0]              mem_wd;
  logic [`FXA_MEM_AW-1:0]  mem_wa;

  // one-cycle answer: the response flops load in the setup cycle
  wire logic setup  = psel & ~penable;
  wire logic access = psel & penable & pready_ff;
  wire logic busy   = (state_ff != FXA_ST_IDLE);

  function automatic logic known_off(input logic [11:0] a);
    known_off = (a == `FXA_OFF_CTRL) || (a == `FXA_OFF_WORK) || (a == `FXA_OFF_FLAGS)
             || (a == `FXA_OFF_ADDR) || (a == `FXA_OFF_MEMDATA) || (a == `FXA_OFF_STATUS);
  endfunction : known_off

  // execution datapath
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [7:0] res;
  logic       cin, to_mem, upd_arith, upd_null, do_mem_write;
  always_comb begin
    cin       = 1'b0;
    to_mem    = 1'b0;
    upd_arith = 1'b0;
    upd_null  = 1'b0;
    res       = 8'h00;
    unique case (op_ff)
      FXA_OP_ADC_W, FXA_OP_ADC_M: cin = flags_ff[`FXA_FLG_CARRY];
      default: cin = 1'b0;
    endcase
    sum9 = {1'b0, work_ff} + {1'b0, opnd_ff} + {8'h00, cin};
    // nibble carry counts the carry in, like the byte carry
    sum5 = {1'b0, work_ff[3:0]} + {1'b0, opnd_ff[3:0]} + {4'h0, cin};
    unique case (op_ff)
      FXA_OP_ADC_W, FXA_OP_ADD_W: begin
        res       = sum9[7:0];
        upd_arith = 1'b1;
        upd_null  = 1'b1;
      end
      FXA_OP_ADC_M, FXA_OP_ADD_M: begin
        res       = sum9[7:0];
        upd_arith = 1'b1;
        upd_null  = 1'b1;
        to_mem    = 1'b1;
      end
      FXA_OP_AND_W: begin
        res      = work_ff & opnd_ff;
        upd_null = 1'b1;
      end
      FXA_OP_AND_M: begin
        res      = work_ff & opnd_ff;
        upd_null = 1'b1;
        to_mem   = 1'b1;
      end
      FXA_OP_CLR_B: begin
        res    = 8'h00;
        to_mem = 1'b1;
      end
      FXA_OP_CLR_I: begin
        res    = opnd_ff & ~(8'h01 << bit_ff);
        to_mem = 1'b1;
      end
    endcase
  end

  // signed wrap: like-signed operands giving an unlike-signed sum
  wire logic wrap_v = (work_ff[7] == opnd_ff[7]) && (sum9[7] != work_ff[7]);

  always_comb begin
    nxt_state   = state_ff;
    nxt_work    = work_ff;
    nxt_flags   = flags_ff;
    nxt_addr    = addr_ff;
    nxt_op      = op_ff;
    nxt_bit     = bit_ff;
    nxt_opnd    = opnd_ff;
    nxt_prdata  = prdata_ff;
    nxt_pready  = 1'b0;
    nxt_pslverr = 1'b0;
    mem_we      = 1'b0;
    mem_wd      = pwdata[7:0];
    mem_wa      = addr_ff;
    do_mem_write = 1'b0;
    // read data sampled in the setup cycle, shown in the access cycle
    if (setup) begin
      nxt_pready  = 1'b1;
      nxt_pslverr = ~known_off(paddr);
      unique case (paddr)
        `FXA_OFF_CTRL:    nxt_prdata = {24'h0, 5'h0, bit_ff};
        `FXA_OFF_WORK:    nxt_prdata = {24'h0, work_ff};
        `FXA_OFF_FLAGS:   nxt_prdata = {27'h0, flags_ff};
        `FXA_OFF_ADDR:    nxt_prdata = {22'h0, addr_ff};
        `FXA_OFF_MEMDATA: nxt_prdata = {24'h0, mem[addr_ff]};
        `FXA_OFF_STATUS:  nxt_prdata = {31'h0, busy};
        default:          nxt_prdata = 32'h0;
      endcase
    end

    // sequencer: idle, fetch operand, write back
    // bus writes far_and_into_work only while idle; a busy block drops them silently
    unique case (state_ff)
      FXA_ST_IDLE: begin
        if (access && pwrite) begin
          unique case (paddr)
            `FXA_OFF_CTRL: if (pwdata[`FXA_CTRL_GO]) begin
              nxt_op    = fxa_op_t'(pwdata[`FXA_CTRL_OP_LSB +: 3]);
              nxt_bit   = pwdata[`FXA_CTRL_BIT_LSB +: 3];
              nxt_state = FXA_ST_READ;
            end
            `FXA_OFF_WORK:  nxt_work  = pwdata[7:0];
            `FXA_OFF_FLAGS: nxt_flags = pwdata[4:0];
            `FXA_OFF_ADDR:  nxt_addr  = pwdata[`FXA_MEM_AW-1:0];
            `FXA_OFF_MEMDATA: mem_we = 1'b1;
            default: ;
          endcase
        end
      end
      FXA_ST_READ: begin
        nxt_opnd  = mem[addr_ff];
        nxt_state = FXA_ST_WRITE;
      end
      FXA_ST_WRITE: begin
        // operand fetched a cycle earlier; bus writes ignored while busy
        if (to_mem) begin
          mem_we = 1'b1;
          mem_wd = res;
        end else begin
          nxt_work = res;
        end
        if (upd_arith) begin
          nxt_flags[`FXA_FLG_CARRY]  = sum9[8];
          nxt_flags[`FXA_FLG_NIBBLE] = sum5[4];
          nxt_flags[`FXA_FLG_WRAP]   = wrap_v;
          nxt_flags[`FXA_FLG_SIGN]   = sum9[7] ^ wrap_v;
        end
        if (upd_null) nxt_flags[`FXA_FLG_NULL] = (res == 8'h00);
        nxt_state = FXA_ST_IDLE;
      end
    endcase
    do_mem_write = mem_we;
  end

  // one write port, shared by the bus and the write-back state
  always_ff @(posedge pclk) begin
    if (do_mem_write) mem[mem_wa] <= mem_wd;
  end

  // registered answers keep every bus output straight off a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff   <= FXA_ST_IDLE;
      work_ff    <= `FXA_RST_WORK;
      flags_ff   <= `FXA_RST_FLAGS;
      addr_ff    <= `FXA_RST_ADDR;
      op_ff      <= FXA_OP_ADC_W;
      bit_ff     <= 3'h0;
      opnd_ff    <= 8'h00;
      prdata_ff  <= 32'h0;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      work_ff    <= nxt_work;
      flags_ff   <= nxt_flags;
      addr_ff    <= nxt_addr;
      op_ff      <= nxt_op;
      bit_ff     <= nxt_bit;
      opnd_ff    <= nxt_opnd;
      prdata_ff  <= nxt_prdata;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;

  // checks: arithmetic group
  AST_ADD_WORK: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == FXA_ST_WRITE && op_ff == FXA_OP_ADD_W
    |=> work_ff == 8'($past(sum9))) else $error("add into work wrong");

  AST_ADC_CARRY: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == FXA_ST_WRITE && op_ff == FXA_OP_ADC_W
    |=> {flags_ff[`FXA_FLG_CARRY], work_ff} == $past(sum9)) else $error("carry out wrong");

  AST_ADC_MEM: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == FXA_ST_WRITE && op_ff == FXA_OP_ADC_M
    |-> do_mem_write && mem_wd == sum9[7:0] && nxt_work == work_ff) else $error("adc mem wrong");

  AST_ADD_MEM: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == FXA_ST_WRITE && op_ff == FXA_OP_ADD_M
    |-> do_mem_write && mem_wd == 8'(work_ff + opnd_ff)) else $error("add mem wrong");

  AST_NO_CARRY_IN: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == FXA_ST_WRITE && (op_ff == FXA_OP_ADD_W || op_ff == FXA_OP_ADD_M)
    |-> sum9 == {1'b0, work_ff} + {1'b0, opnd_ff}) else $error("carry leaked in");

  AST_ARITH_FLAGS: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == FXA_ST_WRITE && upd_arith
    |-> nxt_flags[`FXA_FLG_NIBBLE] == sum5[4]
     && nxt_flags[`FXA_FLG_SIGN] == (res[7] ^ nxt_flags[`FXA_FLG_WRAP])
     && nxt_flags[`FXA_FLG_WRAP] == ((work_ff[7] ~^ opnd_ff[7]) & (res[7] ^ work_ff[7])))
    else $error("arith flags wrong");

  // logical group
  AST_AND_FLAGS: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == FXA_ST_WRITE && op_ff == FXA_OP_AND_W
    |=> ((flags_ff ^ $past(flags_ff)) & ~(5'h01 << `FXA_FLG_NULL)) == 5'h00
     && work_ff == ($past(work_ff) & $past(opnd_ff))) else $error("and work wrong");

  AST_AND_MEM: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == FXA_ST_WRITE && op_ff == FXA_OP_AND_M
    |-> do_mem_write && mem_wd == (work_ff & opnd_ff)) else $error("and mem wrong");

  AST_AND_MEM_FLAGS: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == FXA_ST_WRITE && op_ff == FXA_OP_AND_M
    |=> ((flags_ff ^ $past(flags_ff)) & ~(5'h01 << `FXA_FLG_NULL)) == 5'h00)
    else $error("and mem flags wrong");

  // clear group, then the null flag of the arithmetic and logical ops
  AST_CLR_BYTE: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == FXA_ST_WRITE && op_ff == FXA_OP_CLR_B
    |=> flags_ff == $past(flags_ff) && $past(do_mem_write) && $past(mem_wd) == 8'h00)
    else $error("clear byte wrong");

  AST_CLR_BIT: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == FXA_ST_WRITE && op_ff == FXA_OP_CLR_I
    |-> do_mem_write && mem_wd[bit_ff] == 1'b0
     && (mem_wd | (8'h01 << bit_ff)) == (opnd_ff | (8'h01 << bit_ff)))
    else $error("clear bit wrong");

  AST_CLR_BIT_FLAGS: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == FXA_ST_WRITE && op_ff == FXA_OP_CLR_I
    |=> flags_ff == $past(flags_ff)) else $error("clear bit flags wrong");

  AST_NULL: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == FXA_ST_WRITE && upd_null
    |=> flags_ff[`FXA_FLG_NULL] == ($past(res) == 8'h00)) else $error("null flag wrong");

  // destination and sequencing
  AST_WORK_KEPT: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == FXA_ST_WRITE && to_mem
    |=> work_ff == $past(work_ff)) else $error("work changed by memory op");

  AST_WORK_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == FXA_ST_WRITE && !to_mem
    |-> !do_mem_write) else $error("memory written by work op");

  AST_FLAT_ADDR: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == FXA_ST_WRITE && do_mem_write
    |-> mem_wa == addr_ff) else $error("write address not the operand address");

  AST_FETCH: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == FXA_ST_READ |=> state_ff == FXA_ST_WRITE ##1 state_ff == FXA_ST_IDLE)
    else $error("sequence wrong");

  COV_ADC: cover property (@(posedge pclk) state_ff == FXA_ST_WRITE && op_ff == FXA_OP_ADC_M);
  COV_WRAP: cover property (@(posedge pclk) state_ff == FXA_ST_WRITE && upd_arith && wrap_v);
  COV_CLRI: cover property (@(posedge pclk) state_ff == FXA_ST_WRITE && op_ff == FXA_OP_CLR_I);
  COV_NULL: cover property (@(posedge pclk)
    state_ff == FXA_ST_WRITE && upd_null && res == 8'h00);

endmodule : fxa_core
`default_nettype wire

// ---- logic/fxa_cfg.svh ----
`ifndef FXA_CFG_SVH
`define FXA_CFG_SVH
// apb register byte offsets
`define FXA_OFF_CTRL    12'h000
`define FXA_OFF_WORK    12'h004
`define FXA_OFF_FLAGS   12'h008
`define FXA_OFF_ADDR    12'h00c
`define FXA_OFF_MEMDATA 12'h010
`define FXA_OFF_STATUS  12'h014
// ctrl fields
`define FXA_CTRL_OP_LSB  0
`define FXA_CTRL_BIT_LSB 4
`define FXA_CTRL_GO      8
// flag positions in the flags register
`define FXA_FLG_CARRY  0
`define FXA_FLG_NIBBLE 1
`define FXA_FLG_NULL   2
`define FXA_FLG_WRAP   3
`define FXA_FLG_SIGN   4
// reset values
`define FXA_RST_WORK  8'h00
`define FXA_RST_FLAGS 5'h00
`define FXA_RST_ADDR  10'h000
// data memory size: every section, flat address
`define FXA_MEM_AW    10
`define FXA_MEM_WORDS 1024
`endif

// ---- logic/fxa_pkg.sv ----
`default_nettype none
package fxa_pkg;
  typedef enum logic [2:0] {
    FXA_OP_ADC_W = 3'h0,
    FXA_OP_ADC_M = 3'h1,
    FXA_OP_ADD_W = 3'h2,
    FXA_OP_ADD_M = 3'h3,
    FXA_OP_AND_W = 3'h4,
    FXA_OP_AND_M = 3'h5,
    FXA_OP_CLR_B = 3'h6,
    FXA_OP_CLR_I = 3'h7
  } fxa_op_t;

  typedef enum logic [2:0] {
    FXA_ST_IDLE  = 3'b001,
    FXA_ST_READ  = 3'b010,
    FXA_ST_WRITE = 3'b100
  } fxa_state_t;
endpackage : fxa_pkg
`default_nettype wire

// ---- testbench/fxa_apb_master.sv ----
`default_nettype none
module fxa_apb_master (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [11:0] paddr,
  output var  logic [31:0] pwdata,
  output var  logic        hung
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    hung = 1'b0;
  end
  // request held until pready seen high at a rising edge
  task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] q);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) hung <= 1'b1;
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : fxa_apb_master
`default_nettype wire

// ---- testbench/test_fxa_core.sv ----
`default_nettype none
module test_fxa_core;
  import fxa_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, hung;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [32:0] exp_q[$];
  int          n_mismatch, check_count, seed;
  always #10 pclk = ~pclk;
  fxa_core i_fxa_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  fxa_apb_master i_fxa_apb_master (.pclk(pclk), .pready(pready), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .hung(hung));
  task wrap_up;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  task compare(input logic [11:0] a, input logic [32:0] e, input logic [32:0] s);
    check_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR read %h expected %h seen %h", a, e, s);
    end
  endtask : compare
  // status polls are not queued, so the monitor skips them
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && pwrite === 1'b0 && paddr != 12'h014)
      compare(paddr, exp_q.pop_front(), {pslverr, prdata});
  end
  always @(posedge hung) begin
    n_mismatch++;
    wrap_up;
  end
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    i_fxa_apb_master.xfer(1'b1, a, d, q);
  endtask : wr
  task rd(input logic [11:0] a, input logic [32:0] e);
    logic [31:0] q;
    exp_q.push_back(e);
    i_fxa_apb_master.xfer(1'b0, a, 32'h0, q);
  endtask : rd
  initial begin
    logic [31:0] r, q;
    logic [7:0]  w, m, s;
    logic [8:0]  sum;
    logic [4:0]  f, nib;
    logic [2:0]  op, b;
    logic        cin, wrap;
    int          k;
    pclk = 1'b0;
    presetn = 1'b0;
    seed = 54696;
    n_mismatch = 0;
    check_count = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h004, 33'h0);
    rd(12'h008, 33'h0);
    rd(12'h018, {1'b1, 32'h0});
    for (int i = 0; i < 32; i++) begin
      op = i[2:0];
      r = $random(seed);
      w = r[7:0];
      m = r[15:8];
      f = r[20:16];
      b = r[23:21];
      cin = f[0] & (op[2:1] == 2'b00);
      // passes 16 to 23 force a zero result for every op but the bit clear (pass 23), to reach the null flag
      if (i >= 16 && i < 24) m = op[2] ? ~w : 8'h00 - w - {7'h0, cin};
      wr(12'h00c, {22'h0, r[31:24], i[1:0]});
      wr(12'h010, {24'h0, m});
      wr(12'h004, {24'h0, w});
      wr(12'h008, {27'h0, f});
      wr(12'h000, {23'h0, 1'b1, 1'b0, b, 1'b0, op});
      k = 0;
      do begin
        i_fxa_apb_master.xfer(1'b0, 12'h014, 32'h0, q);
        k++;
      end while (q[0] !== 1'b0 && k < 20);
      if (q[0] !== 1'b0) begin
        n_mismatch++;
        wrap_up;
      end
      sum = {1'b0, w} + {1'b0, m} + {8'h0, cin};
      nib = {1'b0, w[3:0]} + {1'b0, m[3:0]} + {4'h0, cin};
      s = sum[7:0];
      wrap = (w[7] == m[7]) && (s[7] != w[7]);
      if (op < 3'h4) f = {s[7] ^ wrap, wrap, s == 8'h00, nib[4], sum[8]};
      if (op[2:1] == 2'b10) s = w & m;
      if (op[2:1] == 2'b10) f[2] = (s == 8'h00);
      if (op == 3'h6) s = 8'h00;
      if (op == 3'h7) s = m & ~(8'h01 << b);
      if (op[0] || op[2:1] == 2'b11) m = s;
      else w = s;
      rd(12'h004, {25'h0, w});
      rd(12'h010, {25'h0, m});
      rd(12'h008, {28'h0, f});
      rd(12'h00c, {23'h0, r[31:24], i[1:0]});
    end
    // second reset mid-run: registers back to zero
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h00c, 33'h0);
    rd(12'h004, 33'h0);
    rd(12'h008, 33'h0);
    wrap_up;
  end
endmodule : test_fxa_core
`default_nettype wire
